// ==== inc/psu_pkg.sv ====
/*
 contents: shared constants for the supply supervisor: timing figures and
 their cycle counts, input bit positions, register offsets and reset values.
 assumes: a 25 MHz mclk; included before every design file.
*/
package psu_pkg;
    localparam int unsigned CLK_KHZ = 25000;
    localparam int unsigned CLK_NS = 40;

    // remote request qualification, ms
    localparam int unsigned ON_DELAY_MS = 45;
    localparam int unsigned OFF_DELAY_MS = 16;
    localparam int unsigned ON_DELAY_CYC = ON_DELAY_MS * CLK_KHZ;
    localparam int unsigned OFF_DELAY_CYC = OFF_DELAY_MS * CLK_KHZ;
    // supply-good low to outputs off, ms
    localparam int unsigned PSOFF_MS = 2;
    localparam int unsigned PSOFF_CYC = PSOFF_MS * CLK_KHZ;
    // over-power persistence, ms
    localparam int unsigned OPP_MS = 6;
    localparam int unsigned OPP_CYC = OPP_MS * CLK_KHZ;
    // over-voltage persistence, us
    localparam int unsigned OVP_US = 700;
    localparam int unsigned OVP_CYC = OVP_US * CLK_KHZ / 1000;
    // line-fail persistence, us
    localparam int unsigned LINE_US = 150;
    localparam int unsigned LINE_CYC = LINE_US * CLK_KHZ / 1000;

    // pwm timing: 65 kHz, dead time 1700 ns rounded up
    localparam int unsigned PWM_KHZ = 65;
    localparam int unsigned DEAD_NS = 1700;
    localparam int unsigned PWM_PERIOD_CYC = CLK_KHZ / PWM_KHZ;
    localparam int unsigned PWM_HALF_CYC = PWM_PERIOD_CYC / 2;
    localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PWM_ON_CYC = PWM_HALF_CYC - DEAD_CYC;
    localparam int unsigned PWM_CNT_W = 9;

    // synchronised input vector layout
    localparam int unsigned SYNC_W = 16;
    localparam int unsigned POS_UV = 0;
    localparam int unsigned POS_OC = 4;
    localparam int unsigned POS_OV = 8;
    localparam int unsigned POS_OPP = 12;
    localparam int unsigned POS_LINE = 13;
    localparam int unsigned POS_REQ = 14;
    localparam int unsigned POS_VCC = 15;
    localparam logic [15:0] SYNC_RESET = 16'h6000;

    // register map, byte offsets
    localparam int unsigned ADR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam int unsigned IRQ_PG_RISE = 0;
    localparam int unsigned IRQ_PG_FALL = 1;
    localparam int unsigned IRQ_LATCH = 2;
    localparam int unsigned IRQ_LINE = 3;

    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_ON,
        SEQ_DROP,
        SEQ_LATCHED
    } seq_type;
endpackage

// ==== hdl/qualify_timer.sv ====
/*
 contents: persistence filter; output rises once the input level has held
 for COUNT consecutive clocks and falls as soon as the level goes away.
 assumes: level already synchronised to mclk.
*/
`timescale 1ns/100ps
module qualify_timer #(
    parameter int unsigned COUNT = 4
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic level,
    output logic qualified
);
    localparam int unsigned CW = $clog2(COUNT + 1);
    logic [CW-1:0] count_reg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            count_reg <= '0;
            qualified <= 1'b0;
        end else if (!level) begin
            count_reg <= '0;
            qualified <= 1'b0;
        end else if (count_reg == CW'(COUNT - 1)) begin
            qualified <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    a_qual_needs_level: assert property (@(posedge mclk) disable iff (!resetn)
        qualified |-> $past(level))
        else $error("qualified without its level");
endmodule

// ==== hdl/pwm_timer.sv ====
/*
 contents: fixed-rate two-phase drive; output a in the first half-period,
 output b in the second, each cut short by the dead time.
 assumes: enable is a registered level on mclk.
*/
`timescale 1ns/100ps
module pwm_timer (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic enable,
    output logic driveOutA,
    output logic driveOutB
);
    import psu_pkg::*;
    localparam logic [PWM_CNT_W-1:0] LAST = PWM_CNT_W'(PWM_PERIOD_CYC - 1);
    localparam logic [PWM_CNT_W-1:0] HALF = PWM_CNT_W'(PWM_HALF_CYC);
    localparam logic [PWM_CNT_W-1:0] ONC = PWM_CNT_W'(PWM_ON_CYC);
    logic [PWM_CNT_W-1:0] phase_reg;

    // period counter, restarts whenever drive is disabled
    always_ff @(posedge mclk) begin
        if (!resetn || !enable) begin
            phase_reg <= '0;
        end else if (phase_reg == LAST) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_reg + 1'b1;
        end
    end

    // alternate halves, dead time at the end of each
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            driveOutA <= 1'b0;
            driveOutB <= 1'b0;
        end else begin
            driveOutA <= enable && (phase_reg < ONC);
            driveOutB <= enable && (phase_reg >= HALF) && (phase_reg < HALF + ONC);
        end
    end

    a_no_overlap: assert property (@(posedge mclk) disable iff (!resetn)
        !(driveOutA && driveOutB))
        else $error("both drive outputs high");
    a_dead_gap: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(driveOutA) |-> !driveOutB [*8])
        else $error("drive b too soon after a");
endmodule

// ==== hdl/psu_supervisor_sequencer.sv ====
/*
 contents: supply supervisor top: input synchronisers, on/off sequencing,
 supply-good control, protection latch-off, pwm drive and a wishbone
 register file with interrupt.
 assumes: comparator inputs are asynchronous levels; one clock, mclk.
*/
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/100ps
// Notes on behaviour
// - request low: enable after 45 ms; request high: disable after 16 ms.
// - every turn-off except a supply over-voltage reset drops supply-good first, outputs off about 2 ms later.
// - supply-good high only while all rails are above under-voltage sense.
// - line sample low for 150 us pulls supply-good low.
// - over-power held over 6 ms: supply-good low, outputs latched off.
// - supply over 7 V resets all sequencing logic.
// - pwm runs from an internal 65 kHz time base.
// - over-voltage monitored on the 3.3 V, 5 V and both 12 V rails.
// - over-current monitored separately on 3.3 V, 5 V and both 12 V rails.
// - any over-current drops supply-good and stops pwm switching.
// - over-voltage must persist about 0.7 ms before acting.
module psu_supervisor_sequencer #(
    parameter int unsigned ON_DELAY = psu_pkg::ON_DELAY_CYC,
    parameter int unsigned OFF_DELAY = psu_pkg::OFF_DELAY_CYC,
    parameter int unsigned PSOFF_DELAY = psu_pkg::PSOFF_CYC,
    parameter int unsigned OPP_DELAY = psu_pkg::OPP_CYC,
    parameter int unsigned OVP_DELAY = psu_pkg::OVP_CYC
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic remoteOnRequestN,
    input wire logic lineSampleSense,
    input wire logic overpowerSense,
    input wire logic [3:0] overvoltageTrip,
    input wire logic [3:0] overcurrentTrip,
    input wire logic [3:0] undervoltageTrip,
    input wire logic supplyOvervoltage,
    output logic supplyGoodOut,
    output logic powerEnable,
    output logic driveOutA,
    output logic driveOutB,
    output logic irq,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [psu_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);
    import psu_pkg::*;
    localparam int unsigned DW = $clog2(PSOFF_DELAY + 1);

    logic [SYNC_W-1:0] rawIn;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic coreRstN;
    logic reqOff;
    logic ovAny;
    logic ocAny;
    logic uvAny;
    logic onQual;
    logic offQual;
    logic oppQual;
    logic ovQual;
    logic lineFail;
    logic fault;
    seq_type state_reg;
    seq_type state_next;
    logic latchPend_reg;
    logic [DW-1:0] drop_reg;
    logic pgNext;
    logic lineFailDly_reg;
    logic [7:0] ctrl_reg;
    logic [3:0] irqStatus_reg;
    logic [3:0] irqMask_reg;
    logic [3:0] events;
    logic ackReg;
    logic [31:0] datReg;
    logic access;
    logic wrEn;

    assign rawIn = {supplyOvervoltage, remoteOnRequestN, lineSampleSense, overpowerSense,
                    overvoltageTrip, overcurrentTrip, undervoltageTrip};

    // two-flop synchronisers
    generate
        for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    meta_reg[i] <= SYNC_RESET[i];
                    sync_reg[i] <= SYNC_RESET[i];
                end else begin
                    meta_reg[i] <= rawIn[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    // supply over-voltage holds all sequencing in reset
    assign coreRstN = resetn && !sync_reg[POS_VCC];
    assign reqOff = sync_reg[POS_REQ] || ctrl_reg[0];
    assign ovAny = |sync_reg[POS_OV +: 4];
    assign ocAny = |sync_reg[POS_OC +: 4];
    assign uvAny = |sync_reg[POS_UV +: 4];

    // request qualification
    qualify_timer #(.COUNT(ON_DELAY)) u_on (
        .mclk(mclk),
        .resetn(coreRstN),
        .level(!reqOff),
        .qualified(onQual)
    );
    qualify_timer #(.COUNT(OFF_DELAY)) u_off (
        .mclk(mclk),
        .resetn(coreRstN),
        .level(reqOff),
        .qualified(offQual)
    );
    // over-power persistence
    qualify_timer #(.COUNT(OPP_DELAY)) u_opp (
        .mclk(mclk),
        .resetn(coreRstN),
        .level(sync_reg[POS_OPP]),
        .qualified(oppQual)
    );
    // over-voltage persistence
    qualify_timer #(.COUNT(OVP_DELAY)) u_ovp (
        .mclk(mclk),
        .resetn(coreRstN),
        .level(ovAny),
        .qualified(ovQual)
    );
    // line sample low persistence
    qualify_timer #(.COUNT(LINE_CYC)) u_line (
        .mclk(mclk),
        .resetn(coreRstN),
        .level(!sync_reg[POS_LINE]),
        .qualified(lineFail)
    );

    assign fault = oppQual || ovQual || ocAny;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEQ_OFF: begin
                if (onQual) begin
                    state_next = SEQ_ON;
                end
            end
            SEQ_ON: begin
                if (fault || offQual) begin
                    state_next = SEQ_DROP;
                end
            end
            SEQ_DROP: begin
                if (drop_reg == DW'(PSOFF_DELAY - 1)) begin
                    state_next = latchPend_reg ? SEQ_LATCHED : SEQ_OFF;
                end
            end
            SEQ_LATCHED: begin
                if (offQual) begin
                    state_next = SEQ_OFF;
                end
            end
            default: state_next = SEQ_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!coreRstN) begin
            state_reg <= SEQ_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // latch-off pending once a protection fault ends the on state
    always_ff @(posedge mclk) begin
        if (!coreRstN) begin
            latchPend_reg <= 1'b0;
        end else if (state_reg == SEQ_ON && fault) begin
            latchPend_reg <= 1'b1;
        end else if (state_reg == SEQ_OFF) begin
            latchPend_reg <= 1'b0;
        end
    end

    // supply-good low to outputs off interval
    always_ff @(posedge mclk) begin
        if (!coreRstN || state_reg != SEQ_DROP) begin
            drop_reg <= '0;
        end else begin
            drop_reg <= drop_reg + 1'b1;
        end
    end

    // supply-good
    assign pgNext = (state_next == SEQ_ON) && !uvAny && !lineFail && !fault;

    always_ff @(posedge mclk) begin
        if (!coreRstN) begin
            supplyGoodOut <= 1'b0;
            powerEnable <= 1'b0;
        end else begin
            supplyGoodOut <= pgNext;
            powerEnable <= (state_next == SEQ_ON) || (state_next == SEQ_DROP);
        end
    end

    // drive stops with the outputs
    pwm_timer u_pwm (
        .mclk(mclk),
        .resetn(coreRstN),
        .enable(powerEnable),
        .driveOutA(driveOutA),
        .driveOutB(driveOutB)
    );

    // interrupt events
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            lineFailDly_reg <= 1'b0;
        end else begin
            lineFailDly_reg <= lineFail;
        end
    end

    always_comb begin
        events = 4'h0;
        events[IRQ_PG_RISE] = pgNext && !supplyGoodOut;
        events[IRQ_PG_FALL] = !pgNext && supplyGoodOut;
        events[IRQ_LATCH] = (state_next == SEQ_LATCHED) && (state_reg != SEQ_LATCHED);
        events[IRQ_LINE] = lineFail && !lineFailDly_reg;
    end

    // wishbone classic slave, one wait state
    assign access = cyc_i && stb_i;
    assign wrEn = access && we_i && ackReg && sel_i[0];
    assign ack_o = ackReg;
    assign dat_o = datReg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ackReg <= 1'b0;
            datReg <= 32'h0000_0000;
        end else begin
            ackReg <= access && !ackReg;
            case (adr_i)
                OFS_CTRL: datReg <= {24'h00_0000, ctrl_reg};
                OFS_STATUS: datReg <= {24'h00_0000, latchPend_reg, lineFail, ovQual,
                                       oppQual, ocAny, uvAny, powerEnable, supplyGoodOut};
                OFS_IRQ_STATUS: datReg <= {28'h000_0000, irqStatus_reg};
                OFS_IRQ_MASK: datReg <= {28'h000_0000, irqMask_reg};
                default: datReg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_reg <= CTRL_RESET;
            irqMask_reg <= IRQ_MASK_RESET;
        end else if (wrEn && adr_i == OFS_CTRL) begin
            ctrl_reg <= dat_i[7:0];
        end else if (wrEn && adr_i == OFS_IRQ_MASK) begin
            irqMask_reg <= dat_i[3:0];
        end
    end

    // write one to clear; a new event wins over the clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irqStatus_reg <= 4'h0;
        end else if (wrEn && adr_i == OFS_IRQ_STATUS) begin
            irqStatus_reg <= (irqStatus_reg & ~dat_i[3:0]) | events;
        end else begin
            irqStatus_reg <= irqStatus_reg | events;
        end
    end

    assign irq = |(irqStatus_reg & irqMask_reg);

    a_pg_rails_ok: assert property (@(posedge mclk) disable iff (!coreRstN)
        supplyGoodOut |-> $past(!uvAny))
        else $error("supply-good high with a rail under threshold");
    a_pg_before_off: assert property (@(posedge mclk) disable iff (!coreRstN)
        $fell(powerEnable) |-> !supplyGoodOut && $past(state_reg == SEQ_DROP))
        else $error("outputs off without supply-good drop interval");
    a_drop_pg_low: assert property (@(posedge mclk) disable iff (!coreRstN)
        (state_reg == SEQ_DROP) |-> !supplyGoodOut && powerEnable)
        else $error("drop interval with wrong outputs");
    a_line_fail_pg: assert property (@(posedge mclk) disable iff (!coreRstN)
        lineFail |=> !supplyGoodOut)
        else $error("supply-good high during line failure");
    a_opp_latch: assert property (@(posedge mclk) disable iff (!coreRstN)
        (state_reg == SEQ_ON && oppQual) |=> state_reg == SEQ_DROP && latchPend_reg)
        else $error("over-power did not start latch-off");
    a_ov_latch: assert property (@(posedge mclk) disable iff (!coreRstN)
        (state_reg == SEQ_ON && ovQual) |=> !supplyGoodOut && latchPend_reg)
        else $error("over-voltage not acted on");
    a_oc_pg_low: assert property (@(posedge mclk) disable iff (!coreRstN)
        (state_reg == SEQ_ON && ocAny) |=> !supplyGoodOut && state_reg == SEQ_DROP)
        else $error("over-current did not drop supply-good");
    a_latch_holds: assert property (@(posedge mclk) disable iff (!coreRstN)
        (state_reg == SEQ_LATCHED && !offQual) |=> state_reg == SEQ_LATCHED && !powerEnable)
        else $error("latch-off released early");
    a_vcc_reset: assert property (@(posedge mclk) disable iff (!resetn)
        sync_reg[POS_VCC] |=> state_reg == SEQ_OFF && !powerEnable && !supplyGoodOut)
        else $error("supply over-voltage did not reset");
endmodule

// ==== verification/psu_host_model.sv ====
/*
 holds: host and rail model; remote request line and rail under-voltage flags.
 assumes: powerEnable from the supervisor on the shared mclk.
*/
`timescale 1ns/100ps
module psu_host_model #(
    parameter int RISE = 12
) (
    input wire logic mclk,
    input wire logic powerEnable,
    input wire logic reqOn,
    output logic remoteOnRequestN,
    output logic [3:0] undervoltageTrip
);
    int riseCnt;
    initial begin
        riseCnt = 0;
        remoteOnRequestN = 1'b1;
        undervoltageTrip = 4'hf;
    end
    // host holds the line low for on, high for off
    always @(posedge mclk) begin
        remoteOnRequestN <= !reqOn;
    end
    // rails stay under sense level until outputs have been on for RISE cycles
    always @(posedge mclk) begin
        riseCnt <= powerEnable ? (riseCnt < RISE ? riseCnt + 1 : riseCnt) : 0;
        undervoltageTrip <= (powerEnable && riseCnt >= RISE) ? 4'h0 : 4'hf;
    end
endmodule

// ==== verification/psu_supervisor_sequencer_tb.sv ====
/*
 holds: self-checking bench for the supply supervisor.
 assumes: shortened delay parameters and the host and rail model beside it.
*/
`timescale 1ns/100ps
module psu_supervisor_sequencer_tb;
    import psu_pkg::*;
    localparam int ON_D = 40, OFF_D = 30, DROP_D = 25, PWR_D = 35, VOLT_D = 20;
    localparam int GOOD = 0, ENA = 1, IRQB = 2, DA = 3, DB = 4;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic reqOn = 1'b0;
    logic lineSampleSense = 1'b1;
    logic overpowerSense = 1'b0;
    logic supplyOvervoltage = 1'b0;
    logic [3:0] overvoltageTrip = 4'h0;
    logic [3:0] overcurrentTrip = 4'h0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic remoteOnRequestN;
    logic [3:0] undervoltageTrip;
    logic supplyGoodOut, powerEnable, driveOutA, driveOutB, irq, ack_o;
    logic [31:0] dat_o;
    logic [31:0] rdat;
    int n_mismatch = 0;
    int checks = 0;
    wire logic [4:0] obs = {driveOutB, driveOutA, irq, powerEnable, supplyGoodOut};
    logic [4:0] obsS;
    logic ackS;
    logic [31:0] datS;

    // outputs captured where settled, read at the following rising edge
    always @(negedge mclk) begin
        obsS <= obs;
        ackS <= ack_o;
        datS <= dat_o;
    end

    psu_host_model i_psu_host_model (.mclk(mclk), .powerEnable(powerEnable), .reqOn(reqOn),
        .remoteOnRequestN(remoteOnRequestN), .undervoltageTrip(undervoltageTrip));
    psu_supervisor_sequencer #(.ON_DELAY(ON_D), .OFF_DELAY(OFF_D), .PSOFF_DELAY(DROP_D),
        .OPP_DELAY(PWR_D), .OVP_DELAY(VOLT_D)) i_psu_supervisor_sequencer (
        .mclk(mclk), .resetn(resetn), .remoteOnRequestN(remoteOnRequestN),
        .lineSampleSense(lineSampleSense), .overpowerSense(overpowerSense),
        .overvoltageTrip(overvoltageTrip), .overcurrentTrip(overcurrentTrip),
        .undervoltageTrip(undervoltageTrip), .supplyOvervoltage(supplyOvervoltage),
        .supplyGoodOut(supplyGoodOut), .powerEnable(powerEnable), .driveOutA(driveOutA),
        .driveOutB(driveOutB), .irq(irq), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    task automatic chkr(input int n, input int lo, input int hi);
        chk(n, (n >= lo && n <= hi) ? n : lo);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask

    task automatic waitbit(input int b, input logic v, input int lim, input logic must,
                           output int n);
        n = 0;
        while (obsS[b] !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (must && obsS[b] !== v) begin
            chk(n, 32'h0);
            finish_test();
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ackS !== 1'b1 && n < 20);
        if (ackS !== 1'b1) begin
            chk(n, 32'h0);
            finish_test();
        end
        rdat = datS;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    task automatic on();
        int n;
        reqOn <= 1'b1;
        waitbit(GOOD, 1'b1, ON_D + 60, 1'b1, n);
    endtask

    task automatic start();
        resetn <= 1'b0;
        reqOn <= 1'b0;
        lineSampleSense <= 1'b1;
        overpowerSense <= 1'b0;
        overvoltageTrip <= 4'h0;
        overcurrentTrip <= 4'h0;
        supplyOvervoltage <= 1'b0;
        tick(3);
        resetn <= 1'b1;
        on();
    endtask

    task automatic t_regs();
        rd(OFS_CTRL, 32'(CTRL_RESET));
        rd(OFS_IRQ_MASK, 32'(IRQ_MASK_RESET));
        rd(OFS_STATUS, 32'h4);
        wb(1'b1, 4'h1, 32'hff);
        rd(4'h1, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h0);
    endtask

    task automatic t_on();
        int n;
        reqOn <= 1'b1;
        waitbit(ENA, 1'b1, ON_D + 20, 1'b1, n);
        chkr(n, ON_D, ON_D + 10);
        chk(obsS[GOOD], 1'b0);
        waitbit(GOOD, 1'b1, 40, 1'b1, n);
        chkr(n, 10, 24);
        chk(obsS[IRQB], 1'b0);
        rd(OFS_IRQ_STATUS, 32'h1);
        wb(1'b1, OFS_IRQ_MASK, 32'h1);
        chk(obsS[IRQB], 1'b1);
        wb(1'b1, OFS_IRQ_STATUS, 32'h1);
        chk(obsS[IRQB], 1'b0);
        rd(OFS_IRQ_STATUS, 32'h0);
    endtask

    task automatic t_pwm();
        int n;
        int sum;
        sum = 0;
        waitbit(DA, 1'b0, 400, 1'b1, n);
        waitbit(DA, 1'b1, 400, 1'b1, n);
        for (int k = 0; k < 4; k++) begin
            waitbit((k == 1 || k == 2) ? DB : DA, k[0], 400, 1'b1, n);
            chk(n, k[0] ? DEAD_CYC : PWM_ON_CYC);
            sum += n;
        end
        chk(sum, PWM_PERIOD_CYC);
    endtask

    task automatic t_off(input logic viaReg);
        int n;
        if (viaReg) begin
            wb(1'b1, OFS_CTRL, 32'h1);
        end else begin
            reqOn <= 1'b0;
        end
        waitbit(GOOD, 1'b0, OFF_D + 20, 1'b1, n);
        chkr(n, OFF_D - 4, OFF_D + 10);
        chk(obsS[ENA], 1'b1);
        waitbit(ENA, 1'b0, DROP_D + 10, 1'b1, n);
        chkr(n, DROP_D - 2, DROP_D + 2);
        if (viaReg) begin
            wb(1'b1, OFS_CTRL, 32'h0);
        end
    endtask

    task automatic t_opp();
        int n;
        overpowerSense <= 1'b1;
        tick(PWR_D - 5);
        overpowerSense <= 1'b0;
        waitbit(GOOD, 1'b0, 20, 1'b0, n);
        chk(n, 20);
        overpowerSense <= 1'b1;
        waitbit(GOOD, 1'b0, PWR_D + 20, 1'b1, n);
        chkr(n, PWR_D, PWR_D + 6);
        waitbit(ENA, 1'b0, DROP_D + 10, 1'b1, n);
        overpowerSense <= 1'b0;
        waitbit(ENA, 1'b1, ON_D + 40, 1'b0, n);
        chk(n, ON_D + 40);
        reqOn <= 1'b0;
        tick(OFF_D + 10);
        on();
    endtask

    task automatic t_ov();
        int n;
        for (int b = 0; b < 4; b++) begin
            start();
            overvoltageTrip <= 4'h1 << b;
            tick(VOLT_D - 5);
            overvoltageTrip <= 4'h0;
            waitbit(GOOD, 1'b0, 20, 1'b0, n);
            chk(n, 20);
            overvoltageTrip <= 4'h1 << b;
            waitbit(GOOD, 1'b0, VOLT_D + 20, 1'b1, n);
            chkr(n, VOLT_D, VOLT_D + 6);
        end
    endtask

    task automatic t_oc();
        int n;
        for (int b = 0; b < 4; b++) begin
            start();
            overcurrentTrip <= 4'h1 << b;
            waitbit(GOOD, 1'b0, 10, 1'b1, n);
            chkr(n, 1, 6);
            waitbit(ENA, 1'b0, DROP_D + 10, 1'b1, n);
            tick(2);
            waitbit(DA, 1'b1, 400, 1'b0, n);
            chk(n, 400);
        end
    endtask

    task automatic t_line();
        int n;
        start();
        lineSampleSense <= 1'b0;
        tick(3000);
        chk(obsS[GOOD], 1'b1);
        waitbit(GOOD, 1'b0, 800, 1'b1, n);
        chkr(n + 3000, LINE_CYC, LINE_CYC + 8);
        chk(obsS[ENA], 1'b1);
        rd(OFS_STATUS, 32'h42);
        wb(1'b1, OFS_IRQ_MASK, 32'h8);
        chk(obsS[IRQB], 1'b1);
        lineSampleSense <= 1'b1;
    endtask

    task automatic t_vcc();
        int n;
        start();
        wb(1'b1, OFS_IRQ_MASK, 32'h4);
        supplyOvervoltage <= 1'b1;
        waitbit(ENA, 1'b0, 6, 1'b1, n);
        chk(obsS[GOOD], 1'b0);
        tick(2);
        waitbit(DA, 1'b1, 400, 1'b0, n);
        chk(n, 400);
        supplyOvervoltage <= 1'b0;
        rd(OFS_IRQ_MASK, 32'h4);
        waitbit(ENA, 1'b1, ON_D + 20, 1'b1, n);
        chkr(n, ON_D - 4, ON_D + 10);
    endtask

    initial begin
        tick(3);
        resetn <= 1'b1;
        t_regs();
        t_on();
        t_pwm();
        t_off(1'b0);
        on();
        t_off(1'b1);
        on();
        t_opp();
        t_ov();
        t_oc();
        t_line();
        t_vcc();
        finish_test();
    end
endmodule
